// ==== common/compact_timer_pkg.sv ====
// Constants shared by the compact timer and its two helper modules.
// Assumes an 8-bit register port and a 10-bit up counter.
package compact_timer_pkg;

    // ==========================================
    // Widths and counts
    localparam int CNT_W = 10;
    localparam logic [10:0] FULL_PERIOD = 11'h400;
    localparam logic [9:0] CNT_MAX = 10'h3ff;
    localparam int PERIOD_LSB = 7;

    // ==========================================
    // Register offsets
    localparam logic [7:0] OFS_CLOCK_CTRL = 8'h00;
    localparam logic [7:0] OFS_MODE_CTRL = 8'h01;
    localparam logic [7:0] OFS_CNT_LOW = 8'h02;
    localparam logic [7:0] OFS_CNT_HIGH = 8'h03;
    localparam logic [7:0] OFS_CMP_LOW = 8'h04;
    localparam logic [7:0] OFS_CMP_HIGH = 8'h05;
    localparam logic [7:0] OFS_FLAGS = 8'h06;

    // ==========================================
    // Reset values
    localparam logic [7:0] RST_CLOCK_CTRL = 8'h00;
    localparam logic [7:0] RST_MODE_CTRL = 8'h00;
    localparam logic [9:0] RST_CNT = 10'h000;
    localparam logic [9:0] RST_CMP = 10'h000;
    localparam logic [7:0] RST_BYTE = 8'h00;

    // ==========================================
    // Field positions, clock control register
    localparam int POS_PAUSE = 7;
    localparam int POS_CLKSEL = 4;
    localparam int POS_ENABLE = 3;
    localparam int POS_PERIOD = 0;

    // ==========================================
    // Field positions, mode control register
    localparam int POS_MODE = 6;
    localparam int POS_PINFN = 4;
    localparam int POS_LEVEL = 3;
    localparam int POS_POL = 2;
    localparam int POS_SWAP = 1;
    localparam int POS_CCLR = 0;

    // ==========================================
    // Flag register bits
    localparam int POS_FLAG_A = 0;
    localparam int POS_FLAG_P = 1;

    // ==========================================
    // Operating modes
    typedef enum logic [1:0] {
        MODE_COMPARE = 2'h0,
        MODE_UNDEF = 2'h1,
        MODE_PWM = 2'h2,
        MODE_TIMER = 2'h3
    } timer_mode_e;

    // ==========================================
    // Counter clock sources
    localparam logic [2:0] CKS_SYS_DIV4 = 3'h0;
    localparam logic [2:0] CKS_SYS = 3'h1;
    localparam logic [2:0] CKS_H_DIV16 = 3'h2;
    localparam logic [2:0] CKS_H_DIV64 = 3'h3;
    localparam logic [2:0] CKS_SUB_A = 3'h4;
    localparam logic [2:0] CKS_SUB_B = 3'h5;
    localparam logic [2:0] CKS_EXT_RISE = 3'h6;
    localparam logic [2:0] CKS_EXT_FALL = 3'h7;

    // ==========================================
    // Pin function codes
    localparam logic [1:0] PFN_0 = 2'h0;
    localparam logic [1:0] PFN_1 = 2'h1;
    localparam logic [1:0] PFN_2 = 2'h2;
    localparam logic [1:0] PFN_3 = 2'h3;

endpackage

// ==== rtl/compact_timer.sv ====
// Compact 10-bit timer with full-width and period comparators.
// Assumes a single-cycle register port; pins are asynchronous to sys_clk_in.
module compact_timer (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // Register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // Clock pins
    input wire logic external_clock_pin_in,
    input wire logic sub_clock_in,
    // Output pins
    output logic timer_output_pin_out,
    output logic timer_output_pin_inverted_out,
    // Request flags
    output logic compare_a_flag_out,
    output logic period_flag_out
);

    // ==========================================
    // Declarations
    logic [7:0] timer_clock_control_reg;
    logic [7:0] timer_mode_control_reg;
    logic [9:0] count_reg;
    logic [9:0] full_compare_register_reg;
    logic [7:0] byte_buffer_reg;
    logic [7:0] rdata_next;
    logic enable_prev_reg;
    logic count_tick;
    logic start_pulse;
    logic run_count;
    logic [10:0] count_inc;
    logic count_overflow;
    logic period_match;
    logic full_match;
    logic clear_now;
    logic event_a;
    logic event_p;
    logic [10:0] period_span;
    logic [10:0] duty_value;
    logic pwm_active;
    logic wr_clock;
    logic wr_mode;
    logic wr_cmp_low;
    logic wr_cmp_high;
    logic wr_flags;
    logic rd_cnt_high;
    logic rd_cmp_high;

    // Control fields
    logic counter_pause_bit;
    logic [2:0] counter_clock_select;
    logic timer_enable_bit;
    logic [2:0] period_compare_value;
    logic [1:0] operating_mode_field;
    logic [1:0] pin_function_field;
    logic output_level_control;
    logic output_polarity_invert;
    logic pwm_role_swap;
    logic clear_source_select;
    logic is_pwm;

    assign counter_pause_bit = timer_clock_control_reg[compact_timer_pkg::POS_PAUSE];
    assign counter_clock_select =
        timer_clock_control_reg[compact_timer_pkg::POS_CLKSEL +: 3];
    assign timer_enable_bit = timer_clock_control_reg[compact_timer_pkg::POS_ENABLE];
    assign period_compare_value =
        timer_clock_control_reg[compact_timer_pkg::POS_PERIOD +: 3];
    assign operating_mode_field = timer_mode_control_reg[compact_timer_pkg::POS_MODE +: 2];
    assign pin_function_field = timer_mode_control_reg[compact_timer_pkg::POS_PINFN +: 2];
    assign output_level_control = timer_mode_control_reg[compact_timer_pkg::POS_LEVEL];
    assign output_polarity_invert = timer_mode_control_reg[compact_timer_pkg::POS_POL];
    assign pwm_role_swap = timer_mode_control_reg[compact_timer_pkg::POS_SWAP];
    assign clear_source_select = timer_mode_control_reg[compact_timer_pkg::POS_CCLR];
    assign is_pwm = operating_mode_field == compact_timer_pkg::MODE_PWM;

    // ==========================================
    // Register decode
    assign wr_clock = reg_wr_in && reg_addr_in == compact_timer_pkg::OFS_CLOCK_CTRL;
    assign wr_mode = reg_wr_in && reg_addr_in == compact_timer_pkg::OFS_MODE_CTRL;
    assign wr_cmp_low = reg_wr_in && reg_addr_in == compact_timer_pkg::OFS_CMP_LOW;
    assign wr_cmp_high = reg_wr_in && reg_addr_in == compact_timer_pkg::OFS_CMP_HIGH;
    assign wr_flags = reg_wr_in && reg_addr_in == compact_timer_pkg::OFS_FLAGS;
    assign rd_cnt_high = reg_rd_in && reg_addr_in == compact_timer_pkg::OFS_CNT_HIGH;
    assign rd_cmp_high = reg_rd_in && reg_addr_in == compact_timer_pkg::OFS_CMP_HIGH;

    // ==========================================
    // Control registers
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            timer_clock_control_reg <= compact_timer_pkg::RST_CLOCK_CTRL;
        end else if (wr_clock) begin
            timer_clock_control_reg <= reg_wdata_in;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            timer_mode_control_reg <= compact_timer_pkg::RST_MODE_CTRL;
        end else if (wr_mode) begin
            timer_mode_control_reg <= reg_wdata_in;
        end
    end

    // ==========================================
    // Low-byte buffer and full compare value
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            byte_buffer_reg <= compact_timer_pkg::RST_BYTE;
        end else if (wr_cmp_low) begin
            byte_buffer_reg <= reg_wdata_in;
        end else if (rd_cnt_high) begin
            byte_buffer_reg <= count_reg[7:0];
        end else if (rd_cmp_high) begin
            byte_buffer_reg <= full_compare_register_reg[7:0];
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            full_compare_register_reg <= compact_timer_pkg::RST_CMP;
        end else if (wr_cmp_high) begin
            full_compare_register_reg <= {reg_wdata_in[1:0], byte_buffer_reg};
        end
    end

    // ==========================================
    // Enable edge detection
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            enable_prev_reg <= 1'b0;
        end else begin
            enable_prev_reg <= timer_enable_bit;
        end
    end

    assign start_pulse = timer_enable_bit && !enable_prev_reg;

    // ==========================================
    // Count clock
    count_tick_gen u_tick (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .clk_sel_in(counter_clock_select),
        .ext_pin_in(external_clock_pin_in),
        .sub_clk_in(sub_clock_in),
        .tick_out(count_tick)
    );

    // ==========================================
    // Comparators
    assign run_count = count_tick && timer_enable_bit && !counter_pause_bit
        && !start_pulse;
    assign count_inc = {1'b0, count_reg} + 11'h001;
    assign count_overflow = count_reg == compact_timer_pkg::CNT_MAX;

    // Period compare on top three bits, zero falls back to overflow
    always_comb begin
        if (period_compare_value == 3'h0) begin
            period_match = count_overflow;
        end else begin
            period_match = count_inc[9:compact_timer_pkg::PERIOD_LSB] == period_compare_value
                && count_inc[compact_timer_pkg::PERIOD_LSB-1:0] == 7'h00;
        end
    end

    // Zero compare value never matches; counter then overflows
    assign full_match = full_compare_register_reg != 10'h000
        && count_inc[9:0] == full_compare_register_reg;

    always_comb begin
        if (is_pwm) begin
            clear_now = pwm_role_swap ? full_match : period_match;
        end else begin
            clear_now = clear_source_select ? full_match : period_match;
        end
    end

    assign event_a = run_count && full_match;
    assign event_p = run_count && period_match
        && (is_pwm || !clear_source_select);

    // ==========================================
    // Counter
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            count_reg <= compact_timer_pkg::RST_CNT;
        end else if (start_pulse) begin
            count_reg <= compact_timer_pkg::RST_CNT;
        end else if (run_count) begin
            if (clear_now) begin
                count_reg <= compact_timer_pkg::RST_CNT;
            end else begin
                count_reg <= count_inc[9:0];
            end
        end
    end

    // ==========================================
    // PWM waveform
    assign period_span = period_compare_value == 3'h0 ? compact_timer_pkg::FULL_PERIOD
        : {1'b0, period_compare_value, 7'h00};
    assign duty_value = pwm_role_swap ? period_span
        : {1'b0, full_compare_register_reg};
    assign pwm_active = {1'b0, count_reg} < duty_value;

    timer_pin_stage u_pin (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .mode_in(operating_mode_field),
        .pin_fn_in(pin_function_field),
        .level_in(output_level_control),
        .pol_in(output_polarity_invert),
        .start_in(start_pulse),
        .match_a_in(event_a && operating_mode_field == compact_timer_pkg::MODE_COMPARE),
        .pwm_active_in(pwm_active),
        .pin_out(timer_output_pin_out),
        .pin_b_out(timer_output_pin_inverted_out)
    );

    // ==========================================
    // Request flags, set wins over write-one clear
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            compare_a_flag_out <= 1'b0;
        end else if (event_a) begin
            compare_a_flag_out <= 1'b1;
        end else if (wr_flags && reg_wdata_in[compact_timer_pkg::POS_FLAG_A]) begin
            compare_a_flag_out <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            period_flag_out <= 1'b0;
        end else if (event_p) begin
            period_flag_out <= 1'b1;
        end else if (wr_flags && reg_wdata_in[compact_timer_pkg::POS_FLAG_P]) begin
            period_flag_out <= 1'b0;
        end
    end

    // ==========================================
    // Read data
    always_comb begin
        rdata_next = 8'h00;
        if (reg_rd_in) begin
            case (reg_addr_in)
                compact_timer_pkg::OFS_CLOCK_CTRL: rdata_next = timer_clock_control_reg;
                compact_timer_pkg::OFS_MODE_CTRL: rdata_next = timer_mode_control_reg;
                compact_timer_pkg::OFS_CNT_LOW: rdata_next = byte_buffer_reg;
                compact_timer_pkg::OFS_CNT_HIGH: rdata_next = {6'h00, count_reg[9:8]};
                compact_timer_pkg::OFS_CMP_LOW: rdata_next = byte_buffer_reg;
                compact_timer_pkg::OFS_CMP_HIGH:
                    rdata_next = {6'h00, full_compare_register_reg[9:8]};
                compact_timer_pkg::OFS_FLAGS:
                    rdata_next = {6'h00, period_flag_out, compare_a_flag_out};
                default: rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= 8'h00;
        end else begin
            reg_rdata_out <= rdata_next;
        end
    end

endmodule

// ==== rtl/count_tick_gen.sv ====
// Counter clock source selection, producing a one-cycle count tick.
// Assumes the high-speed clock equals the system clock; pins are asynchronous.
module count_tick_gen (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // Control
    input wire logic [2:0] clk_sel_in,
    // Asynchronous pins
    input wire logic ext_pin_in,
    input wire logic sub_clk_in,
    // Tick
    output logic tick_out
);

    // ==========================================
    // Pin synchronisers with agreement filter
    logic [2:0] ext_sync_reg;
    logic [2:0] sub_sync_reg;
    logic ext_filt_reg;
    logic sub_filt_reg;
    logic [5:0] pre_reg;
    logic tick_next;

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            ext_sync_reg <= 3'h0;
            sub_sync_reg <= 3'h0;
            ext_filt_reg <= 1'b0;
            sub_filt_reg <= 1'b0;
        end else begin
            ext_sync_reg <= {ext_sync_reg[1:0], ext_pin_in};
            sub_sync_reg <= {sub_sync_reg[1:0], sub_clk_in};
            if (ext_sync_reg[1] == ext_sync_reg[2]) begin
                ext_filt_reg <= ext_sync_reg[2];
            end
            if (sub_sync_reg[1] == sub_sync_reg[2]) begin
                sub_filt_reg <= sub_sync_reg[2];
            end
        end
    end

    // ==========================================
    // Prescaler and selection
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            pre_reg <= 6'h00;
        end else begin
            pre_reg <= pre_reg + 6'h01;
        end
    end

    always_comb begin
        case (clk_sel_in)
            compact_timer_pkg::CKS_SYS_DIV4: tick_next = &pre_reg[1:0];
            compact_timer_pkg::CKS_SYS: tick_next = 1'b1;
            compact_timer_pkg::CKS_H_DIV16: tick_next = &pre_reg[3:0];
            compact_timer_pkg::CKS_H_DIV64: tick_next = &pre_reg;
            compact_timer_pkg::CKS_SUB_A,
            compact_timer_pkg::CKS_SUB_B: tick_next = sub_filt_reg == 1'b0
                && sub_sync_reg[1] && sub_sync_reg[2];
            compact_timer_pkg::CKS_EXT_RISE: tick_next = ext_filt_reg == 1'b0
                && ext_sync_reg[1] && ext_sync_reg[2];
            compact_timer_pkg::CKS_EXT_FALL: tick_next = ext_filt_reg == 1'b1
                && !ext_sync_reg[1] && !ext_sync_reg[2];
            default: tick_next = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            tick_out <= 1'b0;
        end else begin
            tick_out <= tick_next;
        end
    end

endmodule

// ==== rtl/timer_pin_stage.sv ====
// Output pin logic for compare-match and PWM modes, with polarity.
// Assumes start and match inputs are one-cycle pulses on sys_clk_in.
module timer_pin_stage (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // Configuration
    input wire logic [1:0] mode_in,
    input wire logic [1:0] pin_fn_in,
    input wire logic level_in,
    input wire logic pol_in,
    // Events
    input wire logic start_in,
    input wire logic match_a_in,
    input wire logic pwm_active_in,
    // Pins
    output logic pin_out,
    output logic pin_b_out
);

    logic cmp_level_reg;
    logic level_next;

    // ==========================================
    // Compare-match pin state
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            cmp_level_reg <= 1'b0;
        end else if (start_in) begin
            cmp_level_reg <= level_in;
        end else if (match_a_in) begin
            case (pin_fn_in)
                compact_timer_pkg::PFN_1: cmp_level_reg <= 1'b0;
                compact_timer_pkg::PFN_2: cmp_level_reg <= 1'b1;
                compact_timer_pkg::PFN_3: cmp_level_reg <= ~cmp_level_reg;
                default: cmp_level_reg <= cmp_level_reg;
            endcase
        end
    end

    // ==========================================
    // Mode selection and polarity
    always_comb begin
        level_next = 1'b0;
        case (mode_in)
            compact_timer_pkg::MODE_COMPARE: level_next = cmp_level_reg ^ pol_in;
            compact_timer_pkg::MODE_PWM: begin
                case (pin_fn_in)
                    compact_timer_pkg::PFN_1: level_next = level_in;
                    compact_timer_pkg::PFN_2: level_next = pwm_active_in ? level_in : ~level_in;
                    default: level_next = ~level_in;
                endcase
                level_next = level_next ^ pol_in;
            end
            default: level_next = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            pin_out <= 1'b0;
            pin_b_out <= 1'b1;
        end else begin
            pin_out <= level_next;
            pin_b_out <= ~level_next;
        end
    end

endmodule

// ==== tb/compact_timer_asserts.sv ====
// Port checker for the compact timer, bound into every instance.
// Assumes the register map and field positions of the shared package.
module compact_timer_asserts (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // Register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_rdata_out,
    // Pins and flags
    input wire logic timer_output_pin_out,
    input wire logic timer_output_pin_inverted_out,
    input wire logic compare_a_flag_out,
    input wire logic period_flag_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking dc @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_n_in);
    // ====
    // Shadow copies of the control registers
    logic [7:0] ctl_reg;
    logic [7:0] mod_reg;
    logic wr_ctl;
    logic wr_flg;
    logic rd_hi;
    logic rd_bad;
    assign wr_ctl = reg_wr_in && reg_addr_in == compact_timer_pkg::OFS_CLOCK_CTRL;
    assign wr_flg = reg_wr_in && reg_addr_in == compact_timer_pkg::OFS_FLAGS;
    assign rd_hi = reg_rd_in && reg_addr_in == compact_timer_pkg::OFS_CNT_HIGH;
    assign rd_bad = reg_rd_in && reg_addr_in > compact_timer_pkg::OFS_FLAGS;
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            ctl_reg <= 8'h00;
        end else if (wr_ctl) begin
            ctl_reg <= reg_wdata_in;
        end
    end
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            mod_reg <= 8'h00;
        end else if (reg_wr_in && reg_addr_in == compact_timer_pkg::OFS_MODE_CTRL) begin
            mod_reg <= reg_wdata_in;
        end
    end
    // ====
    // Checks
    twin_pin_a: assert property (
        timer_output_pin_inverted_out == !timer_output_pin_out) else $error("Pins not complementary");
    read_idle_a: assert property (
        !$past(reg_rd_in) |-> reg_rdata_out == 8'h00) else $error("Read data outside answer");
    cnt_high_a: assert property (
        $past(rd_hi) |-> reg_rdata_out[7:2] == 6'h00) else $error("Counter high upper bits set");
    unmap_read_a: assert property (
        $past(rd_bad) |-> reg_rdata_out == 8'h00) else $error("Unmapped read not zero");
    a_flag_hold_a: assert property (
        $fell(compare_a_flag_out) |-> $past(wr_flg) && ($past(reg_wdata_in) & 8'h01) != 8'h00)
        else $error("Compare flag dropped by itself");
    p_flag_hold_a: assert property (
        $fell(period_flag_out) |-> $past(wr_flg) && ($past(reg_wdata_in) & 8'h02) != 8'h00)
        else $error("Period flag dropped by itself");
    start_pin_a: assert property (
        wr_ctl && reg_wdata_in[3] && !ctl_reg[3] && mod_reg[7:6] == 2'h0
        |=> ##[0:2] timer_output_pin_out == (mod_reg[3] ^ mod_reg[2]))
        else $error("Pin not at initial level after enable");
    timer_pin_a: assert property (
        mod_reg[7:6] == 2'h3 && $stable(mod_reg) && $past(mod_reg, 2) == mod_reg
        |-> !timer_output_pin_out) else $error("Pin driven in timer mode");
    p_quiet_a: assert property (
        mod_reg[7:6] != 2'h2 && mod_reg[0] && $stable(mod_reg) && $past(mod_reg, 2) == mod_reg
        && !$past(period_flag_out) |-> !period_flag_out) else $error("Period flag with clear on A");
    cover property (compare_a_flag_out);
    cover property (period_flag_out);
    cover property ($past(reg_rd_in) && reg_rdata_out != 8'h00);
endmodule

bind compact_timer compact_timer_asserts i_chk (
    .sys_clk_in, .rst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
    .reg_rdata_out, .timer_output_pin_out, .timer_output_pin_inverted_out,
    .compare_a_flag_out, .period_flag_out);

// ==== tb/compact_timer_test.sv ====
// Self-checking bench for the compact timer, with expected values worked out inline.
// Assumes the pin partner drives the external and subsystem clock pins.
module compact_timer_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdat;
    logic [7:0] got;
    logic ext_pin;
    logic sub_pin;
    logic pin, pin_b, fa, fp;
    int fail_count = 0;
    int n_checks = 0;
    int cyc = 0;
    int cmp_model;
    int t0, per, hi, v1, v2;
    always #25 sys_clk_in = !sys_clk_in;
    always @(posedge sys_clk_in) cyc++;
    compact_timer i_dut (.sys_clk_in, .rst_n_in, .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdat), .external_clock_pin_in(ext_pin),
        .sub_clock_in(sub_pin), .timer_output_pin_out(pin), .timer_output_pin_inverted_out(pin_b),
        .compare_a_flag_out(fa), .period_flag_out(fp));
    pin_partner i_far (.sys_clk_in, .external_clock_pin_out(ext_pin), .sub_clock_out(sub_pin));
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test;
        if (fail_count == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk_in);
        wr <= 1'b0;
        @(posedge sys_clk_in);
    endtask
    task automatic rreg(input logic [7:0] a, output logic [7:0] d);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk_in);
        rd <= 1'b0;
        #1;
        d = rdat;
        @(posedge sys_clk_in);
    endtask
    task automatic rcnt(output int v);
        logic [7:0] h;
        rreg(8'h03, h);
        rreg(8'h02, got);
        v = {h[1:0], got};
    endtask
    task automatic wait_flag(input bit use_p);
        int t;
        t = 0;
        while ((use_p ? fp : fa) !== 1'b1 && t < 3000) begin
            @(posedge sys_clk_in);
            #1;
            t++;
        end
        check("flag wait", t < 3000, 1);
    endtask
    // ====
    // Scenarios
    initial begin
        void'($urandom(54));
        repeat (6) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        @(posedge sys_clk_in);
        for (int i = 0; i < 8; i++) begin
            rreg(8'(i), got);
            check("reset read", got, 0);
        end
        check("pin pair", {pin, pin_b}, 2'b01);
        repeat (4) begin
            cmp_model = $urandom_range(1023);
            wreg(8'h04, 8'(cmp_model));
            wreg(8'h05, 8'($urandom) & 8'hfc | 8'(cmp_model >> 8));
            rreg(8'h05, got);
            check("cmp high", got, cmp_model >> 8);
            rreg(8'h04, got);
            check("cmp low", got, cmp_model & 255);
        end
        for (int lp = 0; lp < 4; lp++) begin
            wreg(8'h00, 8'h10);
            wreg(8'h01, 8'(lp << 2));
            rreg(8'h01, got);
            check("mode ctrl", got, lp << 2);
            wreg(8'h00, 8'h18);
            repeat (3) @(posedge sys_clk_in);
            check("start pin", {pin, pin_b}, {lp[1] ^ lp[0], !(lp[1] ^ lp[0])});
        end
        wreg(8'h04, 8'd50);
        wreg(8'h05, 8'h00);
        for (int fn = 0; fn < 4; fn++) begin
            wreg(8'h00, 8'h10);
            wreg(8'h01, 8'(fn << 4) | 8'h01);
            wreg(8'h06, 8'h03);
            wreg(8'h00, 8'h18);
            wait_flag(0);
            t0 = cyc;
            repeat (3) @(posedge sys_clk_in);
            check("first match pin", pin, fn >> 1);
            wreg(8'h06, 8'h01);
            wait_flag(0);
            check("clear on A", cyc - t0, 50);
            repeat (3) @(posedge sys_clk_in);
            check("second match pin", pin, fn == 3 ? 0 : fn >> 1);
            check("no P flag", fp, 0);
        end
        wreg(8'h04, 8'h00);
        wreg(8'h05, 8'h00);
        for (int p = 0; p < 3; p++) begin
            per = p == 2 ? 0 : 2 * p + 1;
            wreg(8'h00, 8'h10 | 8'(per));
            wreg(8'h01, 8'h00);
            wreg(8'h06, 8'h03);
            wreg(8'h00, 8'h18 | 8'(per));
            wait_flag(1);
            t0 = cyc;
            wreg(8'h06, 8'h02);
            wait_flag(1);
            check("period", cyc - t0, per ? per * 128 : 1024);
            check("zero compare", fa, 0);
        end
        for (int s = 0; s < 2; s++) begin
            cmp_model = s ? 200 : 32;
            per = s ? 200 : 128;
            wreg(8'h00, 8'h11);
            wreg(8'h04, 8'(cmp_model));
            wreg(8'h05, 8'h00);
            wreg(8'h01, 8'ha8 | 8'(s << 1) | 8'h01);
            wreg(8'h00, 8'h19);
            repeat (20) @(posedge sys_clk_in);
            hi = 0;
            repeat (2 * per) begin
                @(posedge sys_clk_in);
                #1;
                hi += int'(pin);
            end
            check("pwm duty", hi, 2 * (s ? 128 : 32));
        end
        for (int lp = 0; lp < 4; lp++) begin
            wreg(8'h00, 8'h11);
            wreg(8'h01, 8'h88 | 8'((lp % 2) << 4) | 8'((lp / 2) << 2));
            wreg(8'h00, 8'h19);
            repeat (3) @(posedge sys_clk_in);
            check("pwm forced", pin, lp[0] ^ lp[1]);
        end
        for (int k = 4; k < 8; k++) begin
            if (k == 5) continue;
            wreg(8'h00, 8'(k << 4));
            wreg(8'h01, 8'hc0);
            wreg(8'h00, 8'(k << 4) | 8'h08);
            i_far.burst(20);
            repeat (10) @(posedge sys_clk_in);
            rcnt(v1);
            check("pin clock count", v1, 20);
        end
        wreg(8'h00, 8'h10);
        wreg(8'h00, 8'h18);
        wreg(8'h00, 8'h98);
        rcnt(v1);
        repeat (30) @(posedge sys_clk_in);
        rcnt(v2);
        check("paused", v2, v1);
        wreg(8'h00, 8'h18);
        repeat (30) @(posedge sys_clk_in);
        rcnt(v1);
        check("resumed", v1 > v2 && v1 < v2 + 60, 1);
        wreg(8'h00, 8'h10);
        rcnt(v1);
        repeat (30) @(posedge sys_clk_in);
        rcnt(v2);
        check("stopped", v2, v1);
        end_of_test();
    end
    initial begin
        #(20000 * 50);
        fail_count++;
        end_of_test();
    end
endmodule

// ==== tb/pin_partner.sv ====
// Far-side pin model: external count clock and subsystem clock sources.
// Assumes the bench asks for bursts; both pins rest low between them.
module pin_partner (
    // Clock
    input wire logic sys_clk_in,
    // Pins
    output logic external_clock_pin_out,
    output logic sub_clock_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        external_clock_pin_out = 1'b0;
        sub_clock_out = 1'b0;
    end
    // Full pulses, each edge 7 ns after a system clock rising edge, five cycles apart
    task automatic burst(input int n);
        for (int i = 0; i < 2 * n; i++) begin
            repeat (5) @(posedge sys_clk_in);
            #7;
            external_clock_pin_out = !external_clock_pin_out;
            sub_clock_out = !sub_clock_out;
        end
    endtask
endmodule
